// file: rtl/sddf_defines.svh
// timing counts, register offsets, field positions and reset values
// for the sigma-delta decimation filter; definitions only
`ifndef SDDF_DEFINES_SVH
`define SDDF_DEFINES_SVH

// clocking: system clock and modulator bit rate
`define SDDF_CLK_HZ        40000000
`define SDDF_MOD_HZ        8000000
`define SDDF_MOD_DIV       (`SDDF_CLK_HZ / `SDDF_MOD_HZ)
`define SDDF_SINC5_SPS     125000
`define SDDF_SINC5_DEC     (`SDDF_MOD_HZ / `SDDF_SINC5_SPS)
`define SDDF_SINC5_SETTLE  5
`define SDDF_SINC3_SETTLE  3

// register offsets
`define SDDF_ADDR_RESLO    4'h2
`define SDDF_ADDR_RESHI    4'h3
`define SDDF_ADDR_STATUS   4'h4
`define SDDF_ADDR_FILTCFG  4'h5

// filter configuration fields and reset value
`define SDDF_CFG_ODR_LSB   0
`define SDDF_CFG_ODR_MSB   4
`define SDDF_CFG_TYPE_LSB  5
`define SDDF_CFG_TYPE_MSB  6
`define SDDF_CFG_MAINS_LSB 8
`define SDDF_CFG_MAINS_MSB 9
`define SDDF_CFG_MASK      16'h037F
`define SDDF_CFG_RESET     16'h0000

// status fields
`define SDDF_ST_SETTLED    0
`define SDDF_ST_OVERRUN    1
`define SDDF_ST_CNT_LSB    2

// averaging lengths in sinc5 samples, one per output data rate code
`define SDDF_LEN_125000    15'd1
`define SDDF_LEN_62500     15'd2
`define SDDF_LEN_31250     15'd4
`define SDDF_LEN_25000     15'd5
`define SDDF_LEN_15625     15'd8
`define SDDF_LEN_10390     15'd12
`define SDDF_LEN_4994      15'd25
`define SDDF_LEN_2498      15'd50
`define SDDF_LEN_1000      15'd125
`define SDDF_LEN_500       15'd250
`define SDDF_LEN_395       15'd316
`define SDDF_LEN_200       15'd625
`define SDDF_LEN_100       15'd1248
`define SDDF_LEN_59P87     15'd2088
`define SDDF_LEN_49P92     15'd2504
`define SDDF_LEN_20        15'd6250
`define SDDF_LEN_16P7      15'd7485
`define SDDF_LEN_10        15'd12500
`define SDDF_LEN_5         15'd25000

`endif

// file: rtl/sddf_pkg.sv
// types shared by the decimation filter modules
// assumes sddf_defines.svh supplies all numbers
package sddf_pkg;

	// filter response selection
	typedef enum logic [1:0] {
		SDDF_SINC5_SINC1,
		SDDF_SINC3,
		SDDF_ENHANCED,
		SDDF_TYPE_RSVD
	} sddf_filter_type;

	// mains rejection target in enhanced mode
	typedef enum logic [1:0] {
		SDDF_REJ_60,
		SDDF_REJ_50,
		SDDF_REJ_BOTH,
		SDDF_REJ_BOTH_ALT
	} sddf_mains_type;

	// averaging stage progress after a restart
	typedef enum logic [1:0] {
		SDDF_WAIT_SETTLE,
		SDDF_DISCARD,
		SDDF_RUN,
		SDDF_STATE_RSVD
	} sddf_avg_state_type;

endpackage : sddf_pkg

// file: rtl/sddf_sinc5.sv
// fifth-order sinc stage, decimating the modulator bitstream to 125 kSPS
// assumes modEn pulses once per modulator bit, synchronous to clk
`timescale 1ns/1ps
`include "sddf_defines.svh"

module sddf_sinc5
	import sddf_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// modulator side
	input  wire logic        modEn,
	input  wire logic        modBit,
	input  wire logic        restart,
	// decimated samples
	output logic             sampleValid,
	output logic [23:0]      sampleData,
	output logic             sampleSettled
);

	typedef struct packed {
		logic [4:0][31:0] integ;
		logic [4:0][31:0] dly;
		logic [5:0]       phase;
		logic [2:0]       fill;
		logic             valid;
		logic             good;
		logic [23:0]      data;
	} sddf_sinc5_state_type;

	sddf_sinc5_state_type stateReg;
	sddf_sinc5_state_type stateNext;

	////////////////////////////////////////////////////////////////////
	// integrators at bit rate, combs at the decimated rate
	always_comb
	begin
		logic [31:0] x;
		logic [31:0] c;
		logic [31:0] y;
		x = modBit ? 32'h00000001 : 32'hFFFFFFFF;
		c = 32'h00000000;
		y = 32'h00000000;
		stateNext = stateReg;
		stateNext.valid = 1'b0;
		if (restart)
		begin
			stateNext = '0;
		end
		else if (modEn)
		begin
			stateNext.integ[0] = stateReg.integ[0] + x;
			for (int i = 1; i < 5; i++)
				stateNext.integ[i] = stateReg.integ[i] + stateReg.integ[i-1];
			stateNext.phase = stateReg.phase + 6'h01;
			// fixed decimation: output rate never depends on the odr
			if (stateReg.phase == 6'(`SDDF_SINC5_DEC - 1))
			begin
				c = stateReg.integ[4];
				for (int i = 0; i < 5; i++)
				begin
					y = c - stateReg.dly[i];
					stateNext.dly[i] = c;
					c = y;
				end
				stateNext.valid = 1'b1;
				// full scale +1 wraps into bit 30; clip it
				stateNext.data = (c[31:30] == 2'b01) ? 24'h7FFFFF : c[30:7];
				// stage is settled once five outputs have filled it
				stateNext.good =
					(stateReg.fill == 3'(`SDDF_SINC5_SETTLE - 1));
				if (!stateNext.good)
					stateNext.fill = stateReg.fill + 3'h1;
			end
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	assign sampleValid   = stateReg.valid;
	assign sampleData    = stateReg.data;
	assign sampleSettled = stateReg.good;

endmodule : sddf_sinc5

// file: rtl/sddf_fifo2.sv
// two-entry buffer for conversion results, valid/ready on both sides
// assumes the consumer may hold outReady low for any number of cycles
`timescale 1ns/1ps

module sddf_fifo2
	import sddf_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// filling side
	input  wire logic        inValid,
	input  wire logic [23:0] inData,
	output logic             inReady,
	// draining side
	output logic             outValid,
	output logic [23:0]      outData,
	input  wire logic        outReady,
	// fill level
	output logic [1:0]       count
);

	typedef struct packed {
		logic [1:0][23:0] mem;
		logic             wrPtr;
		logic             rdPtr;
		logic [1:0]       cnt;
	} sddf_fifo2_state_type;

	sddf_fifo2_state_type stateReg;
	sddf_fifo2_state_type stateNext;

	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////
	// pointer and count update; full refuses, never overwrites
	assign inReady  = (stateReg.cnt != 2'd2);
	assign outValid = (stateReg.cnt != 2'd0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_comb
	begin
		stateNext = stateReg;
		if (push)
		begin
			stateNext.mem[stateReg.wrPtr] = inData;
			stateNext.wrPtr = ~stateReg.wrPtr;
		end
		if (pop)
			stateNext.rdPtr = ~stateReg.rdPtr;
		if (push && !pop)
			stateNext.cnt = stateReg.cnt + 2'd1;
		else if (pop && !push)
			stateNext.cnt = stateReg.cnt - 2'd1;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	assign outData = stateReg.mem[stateReg.rdPtr];
	assign count   = stateReg.cnt;

endmodule : sddf_fifo2

// file: rtl/sddf_filter.sv
// sigma-delta decimation filter: sinc5 at a fixed rate, then a
// selectable sinc1 or sinc3 averaging stage, register port and buffer
// assumes a 40 MHz clk, modBit synchronous and valid on modSampleEn
`timescale 1ns/1ps
`include "sddf_defines.svh"

module sddf_filter
	import sddf_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// modulator bitstream
	input  wire logic        modBit,
	output logic             modSampleEn,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [15:0]      regRdData,
	// conversion results
	output logic             resValid,
	output logic [23:0]      resData,
	input  wire logic        resReady
);

	typedef struct packed {
		logic [2:0]         divCnt;
		logic               modEn;
		logic [15:0]        cfg;
		logic               restart;
		sddf_avg_state_type phase;
		logic [1:0]         discard;
		logic [14:0]        sampCnt;
		logic [2:0][71:0]   integ;
		logic [2:0][71:0]   dly;
		logic               avgValid;
		logic [23:0]        avgData;
		logic [23:0]        lastRes;
		logic               overrun;
		logic [15:0]        rdData;
	} sddf_filter_state_type;

	sddf_filter_state_type stateReg;
	sddf_filter_state_type stateNext;

	logic        s5Valid;
	logic [23:0] s5Data;
	logic        s5Settled;
	logic        bufReady;
	logic [1:0]  bufCount;

	////////////////////////////////////////////////////////////////////
	// helpers

	// averaging length per odr code; codes past the table read as 5 SPS
	function automatic logic [14:0] odrLength(input logic [4:0] code);
		logic [14:0] len;
		len = `SDDF_LEN_5;
		case (code)
			5'd0:    len = `SDDF_LEN_125000;
			5'd1:    len = `SDDF_LEN_62500;
			5'd2:    len = `SDDF_LEN_31250;
			5'd3:    len = `SDDF_LEN_25000;
			5'd4:    len = `SDDF_LEN_15625;
			5'd5:    len = `SDDF_LEN_10390;
			5'd6:    len = `SDDF_LEN_4994;
			5'd7:    len = `SDDF_LEN_2498;
			5'd8:    len = `SDDF_LEN_1000;
			5'd9:    len = `SDDF_LEN_500;
			5'd10:   len = `SDDF_LEN_395;
			5'd11:   len = `SDDF_LEN_200;
			5'd12:   len = `SDDF_LEN_100;
			5'd13:   len = `SDDF_LEN_59P87;  // notch on 60 Hz
			5'd14:   len = `SDDF_LEN_49P92;  // notch on 50 Hz
			5'd15:   len = `SDDF_LEN_20;
			5'd16:   len = `SDDF_LEN_16P7;   // notches on both
			5'd17:   len = `SDDF_LEN_10;
			5'd18:   len = `SDDF_LEN_5;
			default: len = `SDDF_LEN_5;
		endcase
		return len;
	endfunction : odrLength

	// smallest shift s with 2**s >= len, used to scale the average
	function automatic logic [3:0] lenShift(input logic [14:0] len);
		logic [3:0] s;
		s = 4'd0;
		for (int i = 0; i < 15; i++)
			if ((16'd1 << i) < {1'b0, len})
				s = 4'(i + 1);
		return s;
	endfunction : lenShift

	////////////////////////////////////////////////////////////////////
	// configuration decode

	sddf_filter_type fType;
	sddf_mains_type  mains;
	logic [14:0]     avgLen;
	logic            order3;
	logic [5:0]      scaleSh;

	always_comb
	begin
		// response and rate come from the filter configuration
		fType  = sddf_filter_type'(
			stateReg.cfg[`SDDF_CFG_TYPE_MSB:`SDDF_CFG_TYPE_LSB]);
		mains  = sddf_mains_type'(
			stateReg.cfg[`SDDF_CFG_MAINS_MSB:`SDDF_CFG_MAINS_LSB]);
		avgLen = odrLength(stateReg.cfg[`SDDF_CFG_ODR_MSB:`SDDF_CFG_ODR_LSB]);
		order3 = 1'b0;
		// three responses; the spare code falls back to sinc5+sinc1
		case (fType)
			SDDF_SINC3:
				order3 = 1'b1;  // sinc3 nulls give the deep notch
			SDDF_ENHANCED:
			begin
				// sinc1 at a mains-rejecting rate
				case (mains)
					SDDF_REJ_60: avgLen = `SDDF_LEN_59P87;
					SDDF_REJ_50: avgLen = `SDDF_LEN_49P92;
					default:     avgLen = `SDDF_LEN_16P7;
				endcase
			end
			default:
				order3 = 1'b0;
		endcase
		// gain is len for sinc1, len cubed for sinc3
		scaleSh = order3 ? 6'(3 * lenShift(avgLen))
			: {2'b00, lenShift(avgLen)};
	end

	////////////////////////////////////////////////////////////////////
	// sinc5 stage and result buffer

	sddf_sinc5 u_sinc5 (
		.clk           (clk),
		.resetn        (resetn),
		.modEn         (stateReg.modEn),
		.modBit        (modBit),
		.restart       (stateReg.restart),
		.sampleValid   (s5Valid),
		.sampleData    (s5Data),
		.sampleSettled (s5Settled)
	);

	sddf_fifo2 u_fifo2 (
		.clk      (clk),
		.resetn   (resetn),
		.inValid  (stateReg.avgValid),
		.inData   (stateReg.avgData),
		.inReady  (bufReady),
		.outValid (resValid),
		.outData  (resData),
		.outReady (resReady),
		.count    (bufCount)
	);

	////////////////////////////////////////////////////////////////////
	// next-state logic: divider, registers, averaging stage

	always_comb
	begin
		logic [71:0] x;
		logic [71:0] c;
		logic [71:0] y;
		logic [71:0] scaled;
		logic        done;
		x      = {{48{s5Data[23]}}, s5Data};
		c      = 72'h0;
		y      = 72'h0;
		scaled = 72'h0;
		done   = 1'b0;
		stateNext = stateReg;
		stateNext.restart  = 1'b0;
		stateNext.avgValid = 1'b0;
		stateNext.rdData   = 16'h0000;

		// modulator bit enable from the clock divider
		stateNext.modEn = 1'b0;
		if (stateReg.divCnt == 3'(`SDDF_MOD_DIV - 1))
		begin
			stateNext.divCnt = 3'h0;
			stateNext.modEn  = 1'b1;
		end
		else
			stateNext.divCnt = stateReg.divCnt + 3'h1;

		// register writes; a new configuration restarts conversion
		if (regWr && regAddr == `SDDF_ADDR_FILTCFG)
		begin
			stateNext.cfg     = regWrData & `SDDF_CFG_MASK;
			stateNext.restart = 1'b1;
		end

		// register reads; data stands in the following cycle only
		if (regRd)
		begin
			case (regAddr)
				`SDDF_ADDR_RESLO:
					stateNext.rdData = stateReg.lastRes[15:0];
				`SDDF_ADDR_RESHI:
					stateNext.rdData = {8'h00, stateReg.lastRes[23:16]};
				`SDDF_ADDR_STATUS:
				begin
					stateNext.rdData[`SDDF_ST_SETTLED] =
						(stateReg.phase == SDDF_RUN);
					stateNext.rdData[`SDDF_ST_OVERRUN] = stateReg.overrun;
					stateNext.rdData[`SDDF_ST_CNT_LSB +: 2] = bufCount;
					stateNext.overrun = 1'b0;  // cleared by read
				end
				`SDDF_ADDR_FILTCFG:
					stateNext.rdData = stateReg.cfg;
				default:
					stateNext.rdData = 16'h0000;
			endcase
		end

		// averaging stage over the fixed-rate sinc5 samples
		if (stateReg.restart)
		begin
			stateNext.phase   = SDDF_WAIT_SETTLE;
			stateNext.sampCnt = 15'h0;
			stateNext.integ   = '0;
			stateNext.dly     = '0;
			stateNext.discard = 2'h0;
		end
		else if (s5Valid)
		begin
			case (stateReg.phase)
				SDDF_WAIT_SETTLE:
				begin
					// sinc5 full, so the first block is clean
					if (s5Settled)
						stateNext.phase = order3 ? SDDF_DISCARD : SDDF_RUN;
				end
				SDDF_DISCARD, SDDF_RUN:
					done = 1'b1;
				default:
					stateNext.phase = SDDF_WAIT_SETTLE;
			endcase
		end

		if (done)
		begin
			stateNext.integ[0] = stateReg.integ[0] + x;
			stateNext.integ[1] = stateReg.integ[1] + stateReg.integ[0];
			stateNext.integ[2] = stateReg.integ[2] + stateReg.integ[1];
			// one result per completed block of avgLen samples
			if (stateReg.sampCnt >= avgLen - 15'd1)
			begin
				stateNext.sampCnt = 15'h0;
				if (order3)
				begin
					c = stateNext.integ[2];
					for (int i = 0; i < 3; i++)
					begin
						y = c - stateReg.dly[i];
						stateNext.dly[i] = c;
						c = y;
					end
				end
				else
				begin
					// plain block sum: integrator minus its last value
					c = stateNext.integ[0] - stateReg.dly[0];
					stateNext.dly[0] = stateNext.integ[0];
				end
				scaled = $signed(c) >>> scaleSh;
				// sinc3 throws away two partial results
				if (stateReg.phase == SDDF_DISCARD)
				begin
					if (stateReg.discard == 2'(`SDDF_SINC3_SETTLE - 2))
						stateNext.phase = SDDF_RUN;
					else
						stateNext.discard = stateReg.discard + 2'h1;
				end
				else
				begin
					stateNext.avgValid = 1'b1;
					stateNext.avgData  = scaled[23:0];
					stateNext.lastRes  = scaled[23:0];
				end
			end
			else
				stateNext.sampCnt = stateReg.sampCnt + 15'h1;
		end

		// a full buffer drops the word; set wins over the read clear
		if (stateReg.avgValid && !bufReady)
			stateNext.overrun = 1'b1;
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			stateReg         <= '0;
			stateReg.cfg     <= `SDDF_CFG_RESET;
			stateReg.restart <= 1'b1;
		end
		else
			stateReg <= stateNext;
	end

	assign modSampleEn = stateReg.modEn;
	assign regRdData   = stateReg.rdData;

endmodule : sddf_filter

// file: sim/sddf_filter_monitor.sv
// concurrent checks on the decimation filter top ports
// assumes a bind onto sddf_filter, one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "sddf_defines.svh"

module sddf_filter_monitor
	import sddf_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// modulator
	input  wire logic        modBit,
	input  wire logic        modSampleEn,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [15:0] regRdData,
	// results
	input  wire logic        resValid,
	input  wire logic [23:0] resData,
	input  wire logic        resReady
);
	logic        cfgWr;
	logic [15:0] sinceCfg_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	//////////////////////////////////////////////////////////////
	// restart age; saturates so long runs never wrap
	assign cfgWr = regWr && regAddr == `SDDF_ADDR_FILTCFG;
	always_ff @(posedge clk)
	begin
		if (!resetn || cfgWr)
			sinceCfg_reg <= 16'h0000;
		else if (sinceCfg_reg != 16'hFFFF)
			sinceCfg_reg <= sinceCfg_reg + 16'h0001;
	end

	//////////////////////////////////////////////////////////////
	// properties
	property p_bitRate;
		modSampleEn |=> !modSampleEn [*4] ##1 modSampleEn;
	endproperty
	property p_rdIdle;
		!regRd |=> regRdData == 16'h0000;
	endproperty
	property p_cfgBack;
		cfgWr ##2 (regRd && regAddr == `SDDF_ADDR_FILTCFG)
			|=> regRdData == ($past(regWrData, 3) & `SDDF_CFG_MASK);
	endproperty
	property p_unmapped;
		regRd && regAddr > 4'h5 |=> regRdData == 16'h0000;
	endproperty
	property p_hiByte;
		regRd && regAddr == `SDDF_ADDR_RESHI |=> regRdData[15:8] == 8'h00;
	endproperty
	property p_hold;
		resValid && !resReady |=> resValid && $stable(resData);
	endproperty
	property p_settle;
		$rose(resValid) |-> sinceCfg_reg >= 16'h05DC;
	endproperty
	property p_count;
		regRd && regAddr == `SDDF_ADDR_STATUS
			|=> (regRdData[3:2] != 2'b00) == $past(resValid);
	endproperty
	property p_unsettled;
		cfgWr ##2 (regRd && regAddr == `SDDF_ADDR_STATUS) |=> !regRdData[0];
	endproperty

	a_bitRate: assert property (p_bitRate)
		else $error("modulator strobe spacing wrong");
	a_rdIdle: assert property (p_rdIdle)
		else $error("read data not zero outside read answer");
	a_cfgBack: assert property (p_cfgBack)
		else $error("filter config readback wrong");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_hiByte: assert property (p_hiByte)
		else $error("result upper byte not zero");
	a_hold: assert property (p_hold)
		else $error("result changed while stalled");
	a_settle: assert property (p_settle)
		else $error("result before sinc5 settled");
	a_count: assert property (p_count)
		else $error("status count disagrees with valid");
	a_unsettled: assert property (p_unsettled)
		else $error("settled flag kept across restart");

	// main scenarios seen
	c_back: cover property (cfgWr ##2 regRd);
	c_stall: cover property (resValid && !resReady);
	c_result: cover property ($rose(resValid));
endmodule : sddf_filter_monitor

bind sddf_filter sddf_filter_monitor i_mon (.clk(clk), .resetn(resetn),
	.modBit(modBit), .modSampleEn(modSampleEn), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .resValid(resValid), .resData(resData),
	.resReady(resReady));

// file: sim/sddf_modulator.sv
// behavioural modulator: constant bitstream level on each strobe
// assumes modSampleEn from the filter marks the sampling cycle
`timescale 1ns/1ps

module sddf_modulator
(
	// clock and strobe
	input  wire logic clk,
	input  wire logic modSampleEn,
	// wanted level, 1 = +1
	input  wire logic level,
	// bit to the filter
	output logic      modBit
);
	logic toggle_reg = 1'b0;

	// free toggle so a sample off the strobe shows up as noise
	always @(posedge clk)
		toggle_reg <= !toggle_reg;
	assign modBit = modSampleEn ? level : toggle_reg;
endmodule : sddf_modulator

// file: sim/sddf_filter_test.sv
// self-checking bench for the decimation filter with a bitstream model
// assumes 40 MHz clk and constant modulator levels for predictable sums
`timescale 1ns/1ps

module sddf_filter_test
	import sddf_pkg::*;
;
	logic        clk;
	logic        resetn;
	logic        level;
	logic        modBit;
	logic        modSampleEn;
	logic [3:0]  regAddr;
	logic [15:0] regWrData;
	logic        regWr;
	logic        regRd;
	logic [15:0] regRdData;
	logic        resValid;
	logic [23:0] resData;
	logic        resReady;
	logic [15:0] lfsrReg = 16'h004B;
	int          errTotal = 0;
	int          checked = 0;
	int          lens [6] = '{1, 2, 4, 5, 8, 12};

	//////////////////////////////////////////////////////////////
	// clock, design and far side
	initial clk = 1'b0;
	always #12.5 clk = !clk;
	sddf_filter i_dut (.clk(clk), .resetn(resetn), .modBit(modBit),
		.modSampleEn(modSampleEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .resValid(resValid), .resData(resData),
		.resReady(resReady));
	sddf_modulator i_mod (.clk(clk), .modSampleEn(modSampleEn),
		.level(level), .modBit(modBit));

	//////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsrNext
	// constant input: block sum of full scale, shifted as the scaler does
	function automatic logic [23:0] model(input logic lv, input int len,
		input int k);
		longint x;
		x = lv ? 64'sd8388607 : -64'sd8388608;
		x = x * (len ** k);
		return 24'(x >>> ($clog2(len) * k));
	endfunction : model
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : regWrite
	task automatic regRead(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		d = regRdData;
	endtask : regRead
	// restart, then empty leftovers; restart keeps the buffer
	task automatic restart(input logic [15:0] cfg);
		regWrite(4'h5, cfg);
		resReady <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : restart
	// take one word with random stalls, n = cycles spent
	task automatic getRes(output logic [23:0] d, output int n,
		input int bound);
		for (n = 0; n < bound; n++)
		begin
			@(negedge clk);
			if (resValid === 1'b1 && resReady === 1'b1)
			begin
				d = resData;
				@(posedge clk);
				return;
			end
			@(posedge clk);
			lfsrReg = lfsrNext(lfsrReg);
			resReady <= lfsrReg[0] | lfsrReg[3];
		end
		errTotal++;
		report_and_stop();
	endtask : getRes

	//////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [15:0] rd;
		logic [15:0] w;
		logic [23:0] d;
		int          n;
		int          c;
		resetn = 1'b0;
		level = 1'b0;
		regAddr = 4'h0;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		resReady = 1'b0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		regRead(4'h5, rd);
		check(rd, 16'h0000);
		regRead(4'hF, rd);
		check(rd, 16'h0000);
		regWrite(4'h4, 16'hFFFF);
		regRead(4'h4, rd);
		check(rd, 16'h0000);
		for (c = 0; c < 4; c++)
		begin
			lfsrReg = lfsrNext(lfsrReg);
			w = {lfsrReg[15:10], 2'(c), lfsrReg[7], 2'(c), lfsrReg[4:0]};
			regWrite(4'h5, w);
			regRead(4'h5, rd);
			check(rd, w & 16'h037F);
		end
		regWrite(4'h5, 16'h0000);
		regRead(4'h4, rd);
		check(rd[0], 1'b0);
		$display("test registers done");
		// sinc5 + sinc1 over the short rate codes
		for (c = 0; c < 6; c++)
		begin
			lfsrReg = lfsrNext(lfsrReg);
			level = lfsrReg[2];
			restart(16'(c));
			getRes(d, n, (8 + lens[c]) * 320);
			check(d, model(level, lens[c], 1));
			check(n >= (4 + lens[c]) * 320 - 20, 1'b1);
			check(n <= (6 + lens[c]) * 320 + 20, 1'b1);
			getRes(d, n, (2 + lens[c]) * 320);
			check(d, model(level, lens[c], 1));
		end
		$display("test sinc1 done");
		// sinc3: two results discarded after a restart
		for (c = 0; c < 2; c++)
		begin
			level = c[0];
			restart(16'h0021);
			getRes(d, n, 14 * 320);
			check(d, model(level, 2, 3));
			check(n >= 10 * 320 - 20, 1'b1);
		end
		$display("test sinc3 done");
		// full buffer drops words and flags overrun
		level = 1'b1;
		restart(16'h0000);
		resReady <= 1'b0;
		repeat (10 * 320) @(posedge clk);
		regRead(4'h4, rd);
		check(rd[3:1], 3'b101);
		// every stored result is full scale, so the held word is known
		d = model(level, 1, 1);
		regRead(4'h2, rd);
		check(rd, d[15:0]);
		regRead(4'h3, rd);
		check(rd, {8'h00, d[23:16]});
		for (c = 0; c < 2; c++)
		begin
			getRes(d, n, 400);
			check(d, model(level, 1, 1));
		end
		$display("test overrun done");
		report_and_stop();
	end
endmodule : sddf_filter_test
